//--- dcd_pkg.sv
// Package for the device configuration decoder: register map, fields, timing
package dcd_pkg;

	// Register byte addresses (one aligned word each)
	localparam logic [7:0] ADDR_GSEG = 8'h00;
	localparam logic [7:0] ADDR_OSCSEL = 8'h04;
	localparam logic [7:0] ADDR_OSC = 8'h08;
	localparam logic [7:0] ADDR_WDOG = 8'h0C;
	localparam logic [7:0] ADDR_POR = 8'h10;
	localparam logic [7:0] ADDR_DBG = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;

	// Reset values (erased state: all ones)
	localparam logic [7:0] RST_GSEG = 8'hFF;
	localparam logic [7:0] RST_OSCSEL = 8'hFF;
	localparam logic [7:0] RST_OSC = 8'hFF;
	localparam logic [7:0] RST_WDOG = 8'hFF;
	localparam logic [7:0] RST_POR = 8'hFF;
	localparam logic [7:0] RST_DBG = 8'hFF;

	// Field positions
	localparam int GSEG_WRLOCK_BIT = 0;
	localparam int OSCSEL_SRC_LSB = 0;
	localparam int OSCSEL_TWOSPD_BIT = 7;
	localparam int OSC_PMODE_LSB = 0;
	localparam int OSC_PINFN_BIT = 2;
	localparam int OSC_CKSM_LSB = 6;
	localparam int WDOG_POST_LSB = 0;
	localparam int WDOG_PRE_BIT = 4;
	localparam int WDOG_PLLK_BIT = 5;
	localparam int WDOG_WATCHDOG_WINDOW_DISABLE_BIT = 6;
	localparam int WDOG_FEN_BIT = 7;
	localparam int POR_DLY_LSB = 0;
	localparam int DBG_PAIR_LSB = 0;
	localparam int DBG_TEST_BIT = 5;
	localparam int CTRL_SWDT_BIT = 0;
	localparam int CTRL_SWITCH_BIT = 1;
	localparam int CTRL_PLLSRC_BIT = 2;
	localparam int CTRL_APPLY_BIT = 3;

	// Response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Oscillator source and mode encodings
	typedef enum logic [2:0] {
		DCD_SRC_FRC = 3'h0, DCD_SRC_FRC_PLL = 3'h1, DCD_SRC_PRI = 3'h2,
		DCD_SRC_PRI_PLL = 3'h3, DCD_SRC_SEC = 3'h4, DCD_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
		DCD_SRC_FRC_DIV16 = 3'h6, DCD_SRC_FRC_POST = 3'h7
	} dcd_src_t;
	typedef enum logic [1:0] {
		DCD_PRI_EC = 2'h0, DCD_PRI_XT = 2'h1, DCD_PRI_HS = 2'h2, DCD_PRI_OFF = 2'h3
	} dcd_pri_t;

	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int STARTUP_US = 20;
	localparam int STARTUP_CYC = (STARTUP_US * (CLK_HZ / 1_000_000));
	localparam int POR_BASE_MS = 2;
	localparam int POR_BASE_CYC = POR_BASE_MS * (CLK_HZ / 1000);
	localparam int WDT_CLK_KHZ = 32;
	localparam int WDT_PRE_LO = 32;
	localparam int WDT_PRE_HI = 128;
	localparam int WDT_POST_STEPS = 16;

endpackage : dcd_pkg

//--- dcd_decoder.sv
// Device configuration decoder with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Write-lock field 0 blocks user program writes; 1 permits them.
// - Two-speed field 1 starts on fast RC, then switches to chosen source.
// - Initial oscillator field decodes eight source choices.
// - Switch mode 1x disables both; 01 switching only; 00 switching plus monitor.
// - Outside crystal modes, pin field 1 outputs clock, 0 frees pin as I/O.
// - Primary mode field: 11 off, 10 high-speed, 01 standard crystal, 00 external.
// - Watchdog fuse 1 forces watchdog and its RC clock on permanently.
// - Watchdog fuse 0 lets the software bit start and stop the watchdog.
// - Window field 0 selects window mode, 1 ordinary mode.
// - Lock-wait field 1 holds a PLL switch until lock; 0 does not wait.
// - Prescaler field 1 gives 1:128, 0 gives 1:32.
// - Postscaler field sets ratio; 1111 gives 1:32768, 1110 gives 1:16384.
// - Power-on delay doubles per step from 2 ms to 128 ms; 000 disables.
// - Test port field 1 enables the boundary-scan port, 0 disables it.
// - Debug field routes to pair 1, 2, 3 for 11, 10, 01; 00 reserved.
// - After power-on, execution stays disabled about 20 us for regulator.
// - The regulator hold-off repeats after every power-down.
// - Postscaler has sixteen settings from 1:1 to 1:32768.
// - Base time-out is 1 ms at divide-by-32, 4 ms at divide-by-128.
module dcd_decoder #(
	parameter int STARTUP_CYCLES = dcd_pkg::STARTUP_CYC,
	parameter int POR_BASE_CYCLES = dcd_pkg::POR_BASE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_resume,
	input wire logic pll_lock,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic prog_write_allow,
	output logic start_on_fast_rc,
	output logic [2:0] initial_osc_source,
	output logic [2:0] active_osc_source,
	output logic clock_switch_enable,
	output logic fail_safe_monitor_enable,
	output logic [1:0] primary_osc_mode,
	output logic osc_pin_clock_out,
	output logic osc_pin_gpio,
	output logic watchdog_run,
	output logic low_power_internal_rc_run,
	output logic watchdog_window_mode,
	output logic [7:0] watchdog_prescale_div,
	output logic [3:0] watchdog_postscale_select,
	output logic [15:0] watchdog_postscale_div,
	output logic [7:0] watchdog_base_ms,
	output logic pll_switch_pending,
	output logic power_on_delay_active,
	output logic test_port_active,
	output logic [1:0] debug_pair,
	output logic debug_pair_reserved,
	output logic exec_enable
);
	import dcd_pkg::*;

	// Counters are 32 bits, so the power-on base must leave room for a shift by six
	if (STARTUP_CYCLES < 1 || POR_BASE_CYCLES < 1 || POR_BASE_CYCLES > 33_554_432)
	begin : g_bad_params
		$error("dcd_decoder: cycle counts out of range");
	end

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [7:0] general_segment_protect_config;
	logic [7:0] oscillator_select_config;
	logic [7:0] oscillator_config;
	logic [7:0] watchdog_config;
	logic [7:0] power_on_timer_config;
	logic [7:0] debug_config;
	logic [7:0] shadow_gseg, shadow_oscsel, shadow_osc, shadow_wdog, shadow_por, shadow_dbg;
	logic software_watchdog_enable;
	logic switch_request;
	logic switch_to_pll;
	logic resume_meta, resume_sync, resume_prev;
	logic lock_meta, lock_sync;
	logic [31:0] startup_count;
	logic [31:0] por_count;
	logic startup_busy;
	logic two_speed_done;
	logic [7:0] aw_addr;
	logic aw_held, w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write, do_read;
	logic fresh_start;

	// Byte-lane merge used for every configuration register write
	function automatic logic [7:0] dcd_merge(input logic [7:0] old_v, input logic [31:0] d,
		input logic [3:0] s);
		dcd_merge = s[0] ? d[7:0] : old_v;
	endfunction : dcd_merge

	// Address decode shared by read and write sides
	function automatic logic dcd_mapped(input logic [7:0] a);
		dcd_mapped = (a <= ADDR_STATUS) && (a[1:0] == 2'h0);
	endfunction : dcd_mapped

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two stages each; only the second stage feeds logic
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			resume_meta <= 1'b0;
			resume_sync <= 1'b0;
			resume_prev <= 1'b0;
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
		end
		else
		begin
			resume_meta <= power_resume;
			resume_sync <= resume_meta;
			resume_prev <= resume_sync;
			lock_meta <= pll_lock;
			lock_sync <= lock_meta;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Address and data are latched independently, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (dcd_mapped(aw_addr) && aw_addr != ADDR_STATUS) ? RESP_OKAY
					: RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Software image of the nonvolatile fields; takes effect only on an apply strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			general_segment_protect_config <= RST_GSEG;
			oscillator_select_config <= RST_OSCSEL;
			oscillator_config <= RST_OSC;
			watchdog_config <= RST_WDOG;
			power_on_timer_config <= RST_POR;
			debug_config <= RST_DBG;
		end
		else if (do_write)
		begin
			unique case (aw_addr)
				ADDR_GSEG: general_segment_protect_config <=
					dcd_merge(general_segment_protect_config, w_data, w_strb);
				ADDR_OSCSEL: oscillator_select_config <=
					dcd_merge(oscillator_select_config, w_data, w_strb);
				ADDR_OSC: oscillator_config <= dcd_merge(oscillator_config, w_data, w_strb);
				ADDR_WDOG: watchdog_config <= dcd_merge(watchdog_config, w_data, w_strb);
				ADDR_POR: power_on_timer_config <=
					dcd_merge(power_on_timer_config, w_data, w_strb);
				ADDR_DBG: debug_config <= dcd_merge(debug_config, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// Control register: software watchdog enable and PLL switch target
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			software_watchdog_enable <= 1'b0;
			switch_to_pll <= 1'b0;
		end
		else if (do_write && aw_addr == ADDR_CTRL && w_strb[0])
		begin
			software_watchdog_enable <= w_data[CTRL_SWDT_BIT];
			switch_to_pll <= w_data[CTRL_PLLSRC_BIT];
		end
	end

	// ------------------------------------------------------------
	// Shadow capture
	// ------------------------------------------------------------
	// Captured from reset values and on an apply strobe; decoded outputs use shadows plus the control register bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shadow_gseg <= RST_GSEG;
			shadow_oscsel <= RST_OSCSEL;
			shadow_osc <= RST_OSC;
			shadow_wdog <= RST_WDOG;
			shadow_por <= RST_POR;
			shadow_dbg <= RST_DBG;
		end
		else if (do_write && aw_addr == ADDR_CTRL && w_strb[0] && w_data[CTRL_APPLY_BIT])
		begin
			shadow_gseg <= general_segment_protect_config;
			shadow_oscsel <= oscillator_select_config;
			shadow_osc <= oscillator_config;
			shadow_wdog <= watchdog_config;
			shadow_por <= power_on_timer_config;
			shadow_dbg <= debug_config;
		end
	end

	// ------------------------------------------------------------
	// Regulator hold-off and power-on delay
	// ------------------------------------------------------------
	assign fresh_start = resume_sync && !resume_prev;

	// Hold-off reruns on reset and on each resume from power-down
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			startup_count <= 32'(STARTUP_CYCLES);
		else if (fresh_start)
			startup_count <= 32'(STARTUP_CYCLES);
		else if (startup_count != 32'h0000_0000)
			startup_count <= startup_count - 32'h0000_0001;
	end
	assign startup_busy = (startup_count != 32'h0000_0000);

	// Delay counter loaded with base times 2^(code-1); code 0 means none
	always_ff @(posedge aclk)
	begin
		if (!aresetn || fresh_start)
			por_count <= 32'h0000_0000;
		else if (startup_count == 32'h0000_0001 && shadow_por[POR_DLY_LSB +: 3] != 3'h0)
			por_count <= 32'(POR_BASE_CYCLES) << (shadow_por[POR_DLY_LSB +: 3] - 3'h1);
		else if (por_count != 32'h0000_0000)
			por_count <= por_count - 32'h0000_0001;
	end
	assign power_on_delay_active = startup_busy || (por_count != 32'h0000_0000);
	assign exec_enable = !power_on_delay_active;

	// ------------------------------------------------------------
	// Clock source sequencing
	// ------------------------------------------------------------
	// Two-speed start completes one cycle after the delays expire
	always_ff @(posedge aclk)
	begin
		if (!aresetn || fresh_start)
			two_speed_done <= 1'b0;
		else if (!power_on_delay_active)
			two_speed_done <= 1'b1;
	end
	assign start_on_fast_rc = shadow_oscsel[OSCSEL_TWOSPD_BIT] && !two_speed_done;
	assign initial_osc_source = shadow_oscsel[OSCSEL_SRC_LSB +: 3];
	assign active_osc_source = start_on_fast_rc ? DCD_SRC_FRC : initial_osc_source;

	// Switch request waits for lock only if the lock-wait field is set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			switch_request <= 1'b0;
		else if (do_write && aw_addr == ADDR_CTRL && w_strb[0] && w_data[CTRL_SWITCH_BIT]
			&& clock_switch_enable)
			switch_request <= 1'b1;
		else if (!(switch_to_pll && shadow_wdog[WDOG_PLLK_BIT]) || lock_sync)
			switch_request <= 1'b0;
	end
	assign pll_switch_pending = switch_request;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	assign prog_write_allow = shadow_gseg[GSEG_WRLOCK_BIT];
	assign clock_switch_enable = !shadow_osc[OSC_CKSM_LSB + 1];
	assign fail_safe_monitor_enable = (shadow_osc[OSC_CKSM_LSB +: 2] == 2'h0);
	assign primary_osc_mode = shadow_osc[OSC_PMODE_LSB +: 2];
	// Crystal modes own the pin, so the function field is ignored there
	assign osc_pin_clock_out = (primary_osc_mode != DCD_PRI_XT) && (primary_osc_mode != DCD_PRI_HS)
		&& shadow_osc[OSC_PINFN_BIT];
	assign osc_pin_gpio = (primary_osc_mode != DCD_PRI_XT) && (primary_osc_mode != DCD_PRI_HS)
		&& !shadow_osc[OSC_PINFN_BIT];
	assign watchdog_run = shadow_wdog[WDOG_FEN_BIT] || software_watchdog_enable;
	assign low_power_internal_rc_run = watchdog_run;
	assign watchdog_window_mode = !shadow_wdog[WDOG_WATCHDOG_WINDOW_DISABLE_BIT];
	assign watchdog_prescale_div = shadow_wdog[WDOG_PRE_BIT] ? 8'(WDT_PRE_HI)
		: 8'(WDT_PRE_LO);
	assign watchdog_base_ms = 8'(32'(watchdog_prescale_div) / WDT_CLK_KHZ);
	assign watchdog_postscale_select = shadow_wdog[WDOG_POST_LSB +: 4];
	assign watchdog_postscale_div = 16'h0001 << watchdog_postscale_select;
	assign test_port_active = shadow_dbg[DBG_TEST_BIT];
	assign debug_pair = shadow_dbg[DBG_PAIR_LSB +: 2];
	assign debug_pair_reserved = (debug_pair == 2'h0);

	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	// Status shows live decoded state, not the software image
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= dcd_mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr[7:0])
				ADDR_GSEG: s_axi_rdata <= {24'h000000, general_segment_protect_config};
				ADDR_OSCSEL: s_axi_rdata <= {24'h000000, oscillator_select_config};
				ADDR_OSC: s_axi_rdata <= {24'h000000, oscillator_config};
				ADDR_WDOG: s_axi_rdata <= {24'h000000, watchdog_config};
				ADDR_POR: s_axi_rdata <= {24'h000000, power_on_timer_config};
				ADDR_DBG: s_axi_rdata <= {24'h000000, debug_config};
				ADDR_CTRL: s_axi_rdata <= {29'h0000000, switch_to_pll, switch_request,
					software_watchdog_enable};
				ADDR_STATUS: s_axi_rdata <= {24'h000000, active_osc_source, lock_sync,
					start_on_fast_rc, watchdog_run, power_on_delay_active, exec_enable};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule : dcd_decoder
`default_nettype wire

//--- dcd_properties.sv
// Checker: port relations of the configuration decoder
`timescale 1ns/100ps
`default_nettype none
module dcd_properties #(
	parameter int STARTUP_CYCLES = 4,
	parameter int POR_BASE_CYCLES = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_resume,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic start_on_fast_rc,
	input wire logic [2:0] initial_osc_source,
	input wire logic [2:0] active_osc_source,
	input wire logic clock_switch_enable,
	input wire logic fail_safe_monitor_enable,
	input wire logic [1:0] primary_osc_mode,
	input wire logic osc_pin_clock_out,
	input wire logic osc_pin_gpio,
	input wire logic watchdog_run,
	input wire logic low_power_internal_rc_run,
	input wire logic [7:0] watchdog_prescale_div,
	input wire logic [7:0] watchdog_base_ms,
	input wire logic [3:0] watchdog_postscale_select,
	input wire logic [15:0] watchdog_postscale_div,
	input wire logic power_on_delay_active,
	input wire logic [1:0] debug_pair,
	input wire logic debug_pair_reserved,
	input wire logic exec_enable
);
	// ----------------------------------------
	// Clocking and sequences
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bench runs with a hold-off of four cycles, so the count is written out
	sequence hold_off_s;
		!exec_enable [*4];
	endsequence
	sequence resume_s;
		$rose(power_resume);
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_MONITOR_NEEDS_SWITCH: assert property (fail_safe_monitor_enable |-> clock_switch_enable)
		else $error("monitor on without clock switching");
	AST_PIN_FUNCTION: assert property ((primary_osc_mode == 2'h1 || primary_osc_mode == 2'h2)
		? (!osc_pin_clock_out && !osc_pin_gpio) : (osc_pin_clock_out ^ osc_pin_gpio))
		else $error("oscillator pin function wrong for mode");
	AST_LOW_POWER_INTERNAL_RC_FOLLOWS_WDOG: assert property (low_power_internal_rc_run == watchdog_run)
		else $error("low-power clock not tied to watchdog");
	AST_PRESCALE_BASE: assert property ((watchdog_prescale_div == 8'h80 && watchdog_base_ms == 8'h04)
		|| (watchdog_prescale_div == 8'h20 && watchdog_base_ms == 8'h01))
		else $error("prescaler and base time-out disagree");
	AST_POSTSCALE_RATIO: assert property (watchdog_postscale_div == (16'h0001 << watchdog_postscale_select))
		else $error("postscale ratio wrong");
	AST_PAIR_RESERVED: assert property (debug_pair_reserved == (debug_pair == 2'h0))
		else $error("reserved debug code not flagged");
	AST_EXEC_GATED: assert property (exec_enable != power_on_delay_active)
		else $error("execution enabled during delay");
	AST_STARTUP_HOLD: assert property ($rose(aresetn) |-> hold_off_s)
		else $error("execution enabled inside start-up hold-off");
	AST_RESUME_HOLD: assert property (resume_s |-> ##[1:5] !exec_enable)
		else $error("hold-off not applied on resume");
	AST_ACTIVE_SOURCE: assert property (start_on_fast_rc ? (active_osc_source == 3'h0)
		: (active_osc_source == initial_osc_source))
		else $error("active source wrong");
	AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule : dcd_properties
`default_nettype wire

//--- tb_top.sv
// Testbench for the configuration decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import dcd_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, power_resume = 1'b0, pll_lock = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, primary_osc_mode, debug_pair;
	logic [2:0] initial_osc_source, active_osc_source;
	logic prog_write_allow, start_on_fast_rc, clock_switch_enable, fail_safe_monitor_enable;
	logic osc_pin_clock_out, osc_pin_gpio, watchdog_run, low_power_internal_rc_run, watchdog_window_mode;
	logic [7:0] watchdog_prescale_div, watchdog_base_ms;
	logic [3:0] watchdog_postscale_select;
	logic [15:0] watchdog_postscale_div;
	logic pll_switch_pending, power_on_delay_active, test_port_active, debug_pair_reserved;
	logic exec_enable;
	int miscompares = 0, checks_done = 0;
	localparam int SU = 4;
	localparam int PB = 8;
	// ----------------------------------------
	// Design and clock
	// ----------------------------------------
	dcd_decoder #(.STARTUP_CYCLES(SU), .POR_BASE_CYCLES(PB)) u_dut (.aclk, .aresetn,
		.power_resume, .pll_lock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .prog_write_allow, .start_on_fast_rc,
		.initial_osc_source, .active_osc_source, .clock_switch_enable,
		.fail_safe_monitor_enable, .primary_osc_mode, .osc_pin_clock_out, .osc_pin_gpio,
		.watchdog_run, .low_power_internal_rc_run, .watchdog_window_mode, .watchdog_prescale_div,
		.watchdog_postscale_select, .watchdog_postscale_div, .watchdog_base_ms,
		.pll_switch_pending, .power_on_delay_active, .test_port_active, .debug_pair,
		.debug_pair_reserved, .exec_enable);
	// 50 MHz clock
	always #10 aclk = ~aclk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Address and data are offered together and each is dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		check("write_wait", n < 50, 1);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		check("read_wait", n < 50, 1);
	endtask : axi_read
	// Counts edges until execution comes back, bounded
	task automatic wait_exec(output int n);
		n = 0;
		while (exec_enable !== 1'b1 && n < 2000)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : wait_exec
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		check("exec_in_reset", exec_enable, 0);
		check("delay_in_reset", power_on_delay_active, 1);
		check("fast_rc_start", start_on_fast_rc, 1);
		check("active_start", active_osc_source, 0);
		@(posedge aclk);
		aresetn <= 1'b1;
		wait_exec(n);
		check("startup_span", n >= SU + (PB << 6) && n <= SU + (PB << 6) + 3, 1);
		for (int i = 0; i < 6; i++)
		begin
			axi_read(8'(4 * i), d, r);
			check("reset_value", d, 32'h0000_00FF);
		end
		check("fast_rc_done", start_on_fast_rc, 0);
		check("active_done", active_osc_source, 7);
		check("post_reset", watchdog_postscale_div, 32'h8000);
		check("debug_reset", debug_pair, 2'h3);
		$display("test reset done");
	endtask : t_reset
	// Sixteen field combinations covering every code of every field except two-speed and power-on delay
	task automatic t_sweep;
		logic [1:0] r;
		logic [3:0] v;
		logic xt;
		for (int i = 0; i < 16; i++)
		begin
			v = 4'(i);
			xt = (v[1:0] == 2'h1) || (v[1:0] == 2'h2);
			axi_write(ADDR_GSEG, {31'h0, v[0]}, r);
			axi_write(ADDR_OSCSEL, {29'h0, v[2:0]}, r);
			axi_write(ADDR_OSC, {24'h0, v[3:2], 3'h0, v[2], v[1:0]}, r);
			axi_write(ADDR_WDOG, {24'h0, v[3] & v[2], v[0], v[1], v[2], v}, r);
			axi_write(ADDR_DBG, {26'h0, v[2], 3'h0, v[1:0]}, r);
			axi_write(ADDR_CTRL, {28'h0, 1'b1, 2'h0, v[0]}, r);
			repeat (2) @(posedge aclk);
			check("allow", prog_write_allow, v[0]);
			check("src", initial_osc_source, v[2:0]);
			check("active", active_osc_source, v[2:0]);
			check("switch", clock_switch_enable, !v[3]);
			check("monitor", fail_safe_monitor_enable, v[3:2] == 2'h0);
			check("pmode", primary_osc_mode, v[1:0]);
			check("clkout", osc_pin_clock_out, !xt && v[2]);
			check("gpio", osc_pin_gpio, !xt && !v[2]);
			check("wdrun", watchdog_run, (v[3] & v[2]) | v[0]);
			check("low_power_internal_rc", low_power_internal_rc_run, (v[3] & v[2]) | v[0]);
			check("window", watchdog_window_mode, !v[0]);
			check("pre", watchdog_prescale_div, v[2] ? 128 : 32);
			check("base", watchdog_base_ms, v[2] ? 4 : 1);
			check("post", watchdog_postscale_div, 32'h1 << v);
			check("postsel", watchdog_postscale_select, v);
			check("test", test_port_active, v[2]);
			check("pair", debug_pair, v[1:0]);
			check("rsvd", debug_pair_reserved, v[1:0] == 2'h0);
		end
		$display("test sweep done");
	endtask : t_sweep
	// Each resume reloads the hold-off, followed by the selected delay
	task automatic t_resume;
		logic [1:0] r;
		int n, dl;
		for (int c = 0; c < 4; c++)
		begin
			dl = (c == 0) ? 0 : (PB << (c - 1));
			axi_write(ADDR_POR, 32'(c), r);
			axi_write(ADDR_CTRL, 32'h8, r);
			power_resume <= 1'b1;
			repeat (5) @(posedge aclk);
			check("resume_off", exec_enable, 0);
			wait_exec(n);
			check("resume_span", n + 5 >= SU + dl + 1 && n + 5 <= SU + dl + 6, 1);
			power_resume <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		$display("test resume done");
	endtask : t_resume
	task automatic t_pll;
		logic [1:0] r;
		axi_write(ADDR_OSC, 32'h40, r);
		axi_write(ADDR_WDOG, 32'h20, r);
		axi_write(ADDR_CTRL, 32'h8, r);
		axi_write(ADDR_CTRL, 32'h6, r);
		repeat (10) @(posedge aclk);
		check("pend_wait", pll_switch_pending, 1);
		pll_lock <= 1'b1;
		repeat (6) @(posedge aclk);
		check("pend_lock", pll_switch_pending, 0);
		pll_lock <= 1'b0;
		axi_write(ADDR_WDOG, 32'h0, r);
		axi_write(ADDR_CTRL, 32'h8, r);
		axi_write(ADDR_CTRL, 32'h6, r);
		check("pend_taken", pll_switch_pending, 1);
		repeat (4) @(posedge aclk);
		check("pend_nowait", pll_switch_pending, 0);
		$display("test pll done");
	endtask : t_pll
	// Errors, and a field write that must wait for the apply strobe
	task automatic t_bus;
		logic [31:0] d;
		logic [1:0] r;
		axi_read(8'h20, d, r);
		check("unmapped_resp", r, RESP_SLVERR);
		check("unmapped_data", d, 0);
		axi_write(ADDR_STATUS, 32'h0, r);
		check("status_resp", r, RESP_SLVERR);
		axi_write(ADDR_GSEG, 32'h1, r);
		axi_write(ADDR_CTRL, 32'h8, r);
		axi_write(ADDR_GSEG, 32'h0, r);
		check("wr_resp", r, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check("held", prog_write_allow, 1);
		axi_write(ADDR_CTRL, 32'h8, r);
		repeat (2) @(posedge aclk);
		check("locked", prog_write_allow, 0);
		$display("test bus done");
	endtask : t_bus
	// ----------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (12) @(posedge aclk);
		t_reset();
		t_sweep();
		t_resume();
		t_pll();
		t_bus();
		end_of_test();
	end
	// Whole run is about a thousand cycles; this limit is far beyond it
	initial
	begin
		#1_000_000;
		miscompares++;
		end_of_test();
	end
endmodule : tb_top
bind dcd_decoder dcd_properties #(.STARTUP_CYCLES(STARTUP_CYCLES),
	.POR_BASE_CYCLES(POR_BASE_CYCLES)) u_props (.aclk, .aresetn, .power_resume,
	.s_axi_rvalid, .s_axi_rready, .start_on_fast_rc, .initial_osc_source,
	.active_osc_source, .clock_switch_enable, .fail_safe_monitor_enable, .primary_osc_mode,
	.osc_pin_clock_out, .osc_pin_gpio, .watchdog_run, .low_power_internal_rc_run, .watchdog_prescale_div,
	.watchdog_base_ms, .watchdog_postscale_select, .watchdog_postscale_div,
	.power_on_delay_active, .debug_pair, .debug_pair_reserved, .exec_enable);
`default_nettype wire
